// file: logic/alu_byte_unit.sv
`timescale 1ns/1ps
module alu_byte_unit
	import alu_core_pkg::*;
(
	// operands
	input wire logic [7:0] acc,
	input wire logic [7:0] opnd,
	input wire logic cin,
	input wire alu_op_t op,
	// result
	output alu_out_t out
);

	logic [4:0] lo;
	logic [4:0] hi;
	logic [7:0] b;
	logic ci;
	logic sub;

	always_comb
	begin
		out = '0;
		sub = (op == OP_SUB) || (op == OP_SUBB);
		// subtract as opnd + ~acc + 1, so carry out is the inverse borrow
		b = sub ? ~acc : acc;
		ci = (op == OP_ADD) ? 1'b0 : ((op == OP_SUB) ? 1'b1 : cin);
		lo = {1'b0, opnd[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		hi = {1'b0, opnd[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
		unique case (op)
			OP_ADD, OP_ADDC, OP_SUB, OP_SUBB:
			begin
				out.res = {hi[3:0], lo[3:0]};
				out.carry = hi[4];
				out.dcarry = lo[4];
				// adder inputs of equal sign giving a result of the other sign
				out.ovf = (opnd[7] == b[7]) && (hi[3] != opnd[7]);
				out.wr_c = 1'b1;
				out.wr_dc = 1'b1;
				out.wr_z = 1'b1;
				out.wr_ov = 1'b1;
			end
			OP_AND:
			begin
				out.res = opnd & acc;
				out.wr_z = 1'b1;
			end
			OP_IOR:
			begin
				out.res = opnd | acc;
				out.wr_z = 1'b1;
			end
			OP_XOR:
			begin
				out.res = opnd ^ acc;
				out.wr_z = 1'b1;
			end
			OP_RLC:
			begin
				out.res = {opnd[6:0], cin};
				out.carry = opnd[7];
				out.wr_c = 1'b1;
			end
			OP_RRC:
			begin
				out.res = {cin, opnd[7:1]};
				out.carry = opnd[0];
				out.wr_c = 1'b1;
			end
			OP_RL:
				out.res = {opnd[6:0], opnd[7]};
			OP_RR:
				out.res = {opnd[0], opnd[7:1]};
			OP_MOVFW, OP_MOVWF, OP_MOVFF:
				out.res = opnd;
			OP_MUL, OP_NOP:
				out.res = acc;
		endcase
	end

endmodule : alu_byte_unit

// file: logic/alu_core_pkg.sv
package alu_core_pkg;

	// aligned byte addresses on the register bus
	localparam logic [7:0] ADDR_ACC = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_OPERAND = 8'h08;
	localparam logic [7:0] ADDR_COMMAND = 8'h0c;
	localparam logic [7:0] ADDR_RESULT = 8'h10;
	localparam logic [7:0] ADDR_PRODUCT = 8'h14;
	localparam logic [7:0] ADDR_FILE_BASE = 8'h40;
	localparam int FILE_DEPTH = 16;

	// flag bit positions in the arithmetic status register
	localparam int FLAG_C = 0;
	localparam int FLAG_DC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;
	localparam logic [3:0] STATUS_RESET = 4'h0;

	// command register fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_SRC_LSB = 8;
	localparam int CMD_DST_LSB = 12;
	localparam int CMD_TO_FILE = 16;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		OP_ADD = 4'h0,
		OP_ADDC = 4'h1,
		OP_SUB = 4'h2,
		OP_SUBB = 4'h3,
		OP_AND = 4'h4,
		OP_IOR = 4'h5,
		OP_XOR = 4'h6,
		OP_RLC = 4'h7,
		OP_RRC = 4'h8,
		OP_RL = 4'h9,
		OP_RR = 4'ha,
		OP_MUL = 4'hb,
		OP_MOVFF = 4'hc,
		OP_MOVWF = 4'hd,
		OP_MOVFW = 4'he,
		OP_NOP = 4'hf
	} alu_op_t;

	typedef struct packed {
		logic [7:0] res;
		logic carry;
		logic dcarry;
		logic ovf;
		logic wr_c;
		logic wr_dc;
		logic wr_z;
		logic wr_ov;
	} alu_out_t;

endpackage : alu_core_pkg

// file: logic/alu_status_multiplier_core.sv
`timescale 1ns/1ps
// How it works
// - eight-bit unit adds, subtracts, shifts and does logic operations
// - operations run between the eight-bit accumulator and any file register
// - arithmetic results are two's complement
// - carry, digit carry, zero and overflow flags update per operation
// - in subtraction carry means no borrow, digit carry means no digit borrow
// - overflow set when signed result leaves -128 to 127
// - overflow uses only the sign bits (bit7) of the two adder inputs and of the result
// - eight by eight multiply gives sixteen-bit product in one cycle
// - file-to-file move bypasses the accumulator
// - sixteen-bit instruction words taken on their own command port
// - fetch and execute overlap; each command completes in one cycle
// - accumulator, status and program counter are readable in the register map
// - program counter is sixteen bits, reaching 64K words
module alu_status_multiplier_core
	import alu_core_pkg::*;
#(
	parameter int DEPTH = FILE_DEPTH
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// instruction word from the decoder
	input wire logic [15:0] instr_word,
	input wire logic instr_valid,
	output logic instr_ready,
	// execution state
	output logic [15:0] program_counter,
	output logic [7:0] working_accumulator,
	output logic [3:0] arith_status_register,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	initial
	begin
		if (DEPTH < 2 || DEPTH > 16)
			$error("DEPTH must lie in 2..16");
	end

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [7:0] acc_r;
		logic [3:0] flags_r;
		logic [7:0] operand_r;
		logic [7:0] result_r;
		logic [15:0] product_r;
		logic [15:0] pc_r;
		logic [7:0] aw_addr_r;
		logic aw_have_r;
		logic [31:0] w_data_r;
		logic [3:0] w_strb_r;
		logic w_have_r;
		logic bvalid_r;
		logic [1:0] bresp_r;
		logic rvalid_r;
		logic [31:0] rdata_r;
		logic [1:0] rresp_r;
		logic [DEPTH-1:0][7:0] file_r;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	////////////////////////////////////////////////////////////////////////////
	// command decode and datapath

	alu_op_t op;
	logic [3:0] src_idx;
	logic [3:0] dst_idx;
	logic to_file;
	logic exec_go;
	logic sw_go;
	logic [15:0] cmd;
	logic [7:0] src_val;
	alu_out_t alu_res;
	logic [15:0] mul_prod;
	logic wr_fire;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;

	assign wr_fire = (st_r.aw_have_r || s_axi_awvalid) && (st_r.w_have_r || s_axi_wvalid) && !st_r.bvalid_r;
	assign wr_addr = st_r.aw_have_r ? st_r.aw_addr_r : s_axi_awaddr;
	assign wr_data = st_r.w_have_r ? st_r.w_data_r : s_axi_wdata;
	assign wr_strb = st_r.w_have_r ? st_r.w_strb_r : s_axi_wstrb;
	assign sw_go = wr_fire && (wr_addr == ADDR_COMMAND) && wr_strb[0] && wr_strb[1];

	// the decoder port wins; a software command in the same cycle is dropped,
	// though its bus write still completes with an okay response
	assign instr_ready = 1'b1;
	assign exec_go = instr_valid || sw_go;
	assign cmd = instr_valid ? instr_word : wr_data[15:0];
	assign op = alu_op_t'(cmd[CMD_OP_LSB +: 4]);
	assign src_idx = cmd[CMD_SRC_LSB +: 4];
	assign dst_idx = cmd[CMD_DST_LSB +: 4];
	assign to_file = instr_valid ? instr_word[7] : wr_data[CMD_TO_FILE];

	always_comb
	begin
		if (32'(src_idx) < DEPTH)
			src_val = st_r.file_r[src_idx];
		else
			src_val = st_r.operand_r;
	end

	alu_byte_unit u_alu
	(
		.acc(st_r.acc_r),
		.opnd(src_val),
		.cin(st_r.flags_r[FLAG_C]),
		.op(op),
		.out(alu_res)
	);

	assign mul_prod = st_r.acc_r * src_val;

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		st_nxt = st_r;
		// write channel
		if (s_axi_awvalid && !st_r.aw_have_r && !wr_fire)
		begin
			st_nxt.aw_have_r = 1'b1;
			st_nxt.aw_addr_r = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_r.w_have_r && !wr_fire)
		begin
			st_nxt.w_have_r = 1'b1;
			st_nxt.w_data_r = s_axi_wdata;
			st_nxt.w_strb_r = s_axi_wstrb;
		end
		if (st_r.bvalid_r && s_axi_bready)
			st_nxt.bvalid_r = 1'b0;
		if (wr_fire)
		begin
			st_nxt.aw_have_r = 1'b0;
			st_nxt.w_have_r = 1'b0;
			st_nxt.bvalid_r = 1'b1;
			st_nxt.bresp_r = RESP_OKAY;
			if (wr_addr == ADDR_ACC && wr_strb[0])
				st_nxt.acc_r = wr_data[7:0];
			else if (wr_addr == ADDR_STATUS && wr_strb[0])
				st_nxt.flags_r = wr_data[3:0];
			else if (wr_addr == ADDR_OPERAND && wr_strb[0])
				st_nxt.operand_r = wr_data[7:0];
			else if (wr_addr >= ADDR_FILE_BASE && wr_addr < ADDR_FILE_BASE + 8'(4 * DEPTH))
			begin
				if (wr_strb[0])
					st_nxt.file_r[wr_addr[5:2]] = wr_data[7:0];
			end
			else if (wr_addr != ADDR_COMMAND)
				st_nxt.bresp_r = RESP_SLVERR;
		end
		// read channel
		if (st_r.rvalid_r && s_axi_rready)
			st_nxt.rvalid_r = 1'b0;
		if (s_axi_arvalid && !st_r.rvalid_r)
		begin
			st_nxt.rvalid_r = 1'b1;
			st_nxt.rresp_r = RESP_OKAY;
			st_nxt.rdata_r = '0;
			if (s_axi_araddr == ADDR_ACC)
				st_nxt.rdata_r[7:0] = st_r.acc_r;
			else if (s_axi_araddr == ADDR_STATUS)
				st_nxt.rdata_r[3:0] = st_r.flags_r;
			else if (s_axi_araddr == ADDR_OPERAND)
				st_nxt.rdata_r[7:0] = st_r.operand_r;
			else if (s_axi_araddr == ADDR_COMMAND)
				st_nxt.rdata_r[15:0] = st_r.pc_r;
			else if (s_axi_araddr == ADDR_RESULT)
				st_nxt.rdata_r[7:0] = st_r.result_r;
			else if (s_axi_araddr == ADDR_PRODUCT)
				st_nxt.rdata_r[15:0] = st_r.product_r;
			else if (s_axi_araddr >= ADDR_FILE_BASE && s_axi_araddr < ADDR_FILE_BASE + 8'(4 * DEPTH))
				st_nxt.rdata_r[7:0] = st_r.file_r[s_axi_araddr[5:2]];
			else
				st_nxt.rresp_r = RESP_SLVERR;
		end
		// execute: one command per cycle, program counter advances with each
		if (exec_go)
		begin
			st_nxt.pc_r = st_r.pc_r + 16'h0001;
			if (op == OP_MUL)
				st_nxt.product_r = mul_prod;
			else if (op == OP_MOVFF)
			begin
				if (32'(dst_idx) < DEPTH)
					st_nxt.file_r[dst_idx] = src_val;
				st_nxt.result_r = src_val;
			end
			else if (op == OP_MOVWF)
			begin
				if (32'(dst_idx) < DEPTH)
					st_nxt.file_r[dst_idx] = st_r.acc_r;
				st_nxt.result_r = st_r.acc_r;
			end
			else if (op != OP_NOP)
			begin
				st_nxt.result_r = alu_res.res;
				if (to_file && 32'(src_idx) < DEPTH)
					st_nxt.file_r[src_idx] = alu_res.res;
				else
					st_nxt.acc_r = alu_res.res;
				if (alu_res.wr_c)
					st_nxt.flags_r[FLAG_C] = alu_res.carry;
				if (alu_res.wr_dc)
					st_nxt.flags_r[FLAG_DC] = alu_res.dcarry;
				if (alu_res.wr_z)
					st_nxt.flags_r[FLAG_Z] = (alu_res.res == 8'h00);
				if (alu_res.wr_ov)
					st_nxt.flags_r[FLAG_OV] = alu_res.ovf;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_r <= '0;
			st_r.flags_r <= STATUS_RESET;
		end
		else
			st_r <= st_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign program_counter = st_r.pc_r;
	assign working_accumulator = st_r.acc_r;
	assign arith_status_register = st_r.flags_r;
	assign s_axi_awready = !st_r.aw_have_r;
	assign s_axi_wready = !st_r.w_have_r;
	assign s_axi_bvalid = st_r.bvalid_r;
	assign s_axi_bresp = st_r.bresp_r;
	assign s_axi_arready = !st_r.rvalid_r;
	assign s_axi_rvalid = st_r.rvalid_r;
	assign s_axi_rdata = st_r.rdata_r;
	assign s_axi_rresp = st_r.rresp_r;

endmodule : alu_status_multiplier_core

// file: verification/alu_core_props.sv
`timescale 1ns/1ps
module alu_core_props
	import alu_core_pkg::*;
#(
	parameter int DEPTH = FILE_DEPTH
)
(
	// clock, reset, command
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [15:0] instr_word,
	input wire logic instr_valid,
	// state
	input wire logic [15:0] program_counter,
	input wire logic [7:0] working_accumulator,
	input wire logic [3:0] arith_status_register,
	// read channels
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// accumulator one edge back, sliceable unlike a sampled-value call
	logic [7:0] acc_prev_r;
	always_ff @(posedge aclk)
		acc_prev_r <= working_accumulator;
	sequence s_cmd(logic [3:0] o);
		instr_valid && instr_word[3:0] == o && !instr_word[7];
	endsequence
	////////////////////////
	a_pc_step: assert property (instr_valid |=> program_counter == $past(program_counter) + 16'h1)
		else $error("pc did not step");
	a_add_carry: assert property (s_cmd(OP_ADD) |=> arith_status_register[FLAG_C] == (working_accumulator < acc_prev_r))
		else $error("add carry wrong");
	a_add_digit: assert property (s_cmd(OP_ADD) |=> arith_status_register[FLAG_DC] == (working_accumulator[3:0] < acc_prev_r[3:0]))
		else $error("add digit carry wrong");
	a_ovf_sign: assert property (s_cmd(OP_ADD) |=> !arith_status_register[FLAG_OV] || working_accumulator[7] != acc_prev_r[7])
		else $error("overflow without sign change");
	a_sub_borrow: assert property (s_cmd(OP_SUB) |=> arith_status_register[FLAG_C] == ({1'b0, working_accumulator} + {1'b0, acc_prev_r} < 9'h100))
		else $error("sub borrow wrong");
	a_zero_flag: assert property (instr_valid && !instr_word[7] && instr_word[3:0] inside {OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR} |=> arith_status_register[FLAG_Z] == (working_accumulator == 8'h00))
		else $error("zero flag wrong");
	a_logic_keeps: assert property (instr_valid && instr_word[3:0] inside {OP_AND, OP_IOR, OP_XOR} |=> $stable(arith_status_register[1:0]) && $stable(arith_status_register[3]))
		else $error("logic op touched c, dc or ov");
	a_mul_keeps: assert property (s_cmd(OP_MUL) |=> $stable(arith_status_register) && $stable(working_accumulator))
		else $error("multiply touched acc or flags");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
endmodule : alu_core_props
bind alu_status_multiplier_core alu_core_props #(.DEPTH(DEPTH)) u_alu_core_props (.aclk, .aresetn, .instr_word,
	.instr_valid, .program_counter, .working_accumulator, .arith_status_register, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready);

// file: verification/alu_decoder_model.sv
`timescale 1ns/1ps
module alu_decoder_model
(
	// clock
	input wire logic aclk,
	// command port
	output logic [15:0] instr_word,
	output logic instr_valid,
	input wire logic instr_ready
);
	initial
	begin
		instr_word = 16'h0000;
		instr_valid = 1'b0;
	end
	task automatic issue(input logic [15:0] w);
		logic rdy;
		@(posedge aclk);
		instr_word <= w;
		instr_valid <= 1'b1;
		do
		begin
			@(negedge aclk);
			rdy = instr_ready;
			@(posedge aclk);
		end
		while (!rdy);
		instr_valid <= 1'b0;
		// idle word scrambled so a stale opcode is never mistaken for live
		instr_word <= ~w;
	endtask : issue
endmodule : alu_decoder_model

// file: verification/alu_status_multiplier_core_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module alu_status_multiplier_core_tb;
	import alu_core_pkg::*;
	// small file so source indexes 8..15 reach the operand register
	localparam int DEPTH = 8;
	logic aclk, aresetn, instr_valid, instr_ready;
	logic [15:0] instr_word, program_counter;
	logic [7:0] working_accumulator, s_axi_awaddr, s_axi_araddr;
	logic [3:0] arith_status_register, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] tbl [7] = '{32'hff010007, 32'h7f01080a, 32'h018027f9, 32'h02012ff0, 32'h0ff04004, 32'h5a5a6004,
		32'h50055550};
	int errors = 0;
	int checks = 0;
	int cycles = 0;
	alu_status_multiplier_core #(.DEPTH(DEPTH)) u_alu_status_multiplier_core (.aclk, .aresetn, .instr_word,
		.instr_valid, .instr_ready, .program_counter, .working_accumulator, .arith_status_register, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	alu_decoder_model u_alu_decoder_model (.aclk, .instr_word, .instr_valid, .instr_ready);
	////////////////////////
	task automatic print_verdict();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, b;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(negedge aclk);
			aw = s_axi_awready;
			w = s_axi_wready;
			b = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge aclk);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
		end
		while (!b);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rdreg(input logic [7:0] a);
		logic ar, r;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(negedge aclk);
			ar = s_axi_arready;
			r = s_axi_rvalid;
			rd = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge aclk);
			if (ar)
				s_axi_arvalid <= 1'b0;
		end
		while (!r);
		s_axi_rready <= 1'b0;
	endtask : rdreg
	////////////////////////
	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	// ceiling well above the roughly 120 cycles the tests need
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errors++;
			print_verdict();
		end
	end
	initial
	begin
		aresetn = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		`CHK({program_counter, working_accumulator, arith_status_register}, {16'h0000, 8'h00, STATUS_RESET})
		$display("reset test done");
		foreach (tbl[i])
		begin
			wr(ADDR_STATUS, 32'h00000000);
			wr(ADDR_ACC, {24'h000000, tbl[i][31:24]});
			wr(ADDR_OPERAND, {24'h000000, tbl[i][23:16]});
			u_alu_decoder_model.issue({8'h08, 4'h0, tbl[i][15:12]});
			@(negedge aclk);
			`CHK({working_accumulator, arith_status_register}, tbl[i][11:0])
		end
		$display("arith test done");
		wr(ADDR_ACC, 32'h000000ff);
		wr(ADDR_OPERAND, 32'h000000ff);
		u_alu_decoder_model.issue({8'h08, 4'h0, OP_MUL});
		rdreg(ADDR_PRODUCT);
		`CHK(rd, 32'h0000fe01)
		$display("multiply test done");
		wr(ADDR_OPERAND, 32'h0000003c);
		u_alu_decoder_model.issue({8'h38, 4'h0, OP_MOVFF});
		rdreg(ADDR_FILE_BASE + 8'h0c);
		`CHK({rd, working_accumulator}, {32'h0000003c, 8'hff})
		$display("move test done");
		wr(ADDR_COMMAND, {16'h0000, 8'h00, 4'h0, OP_NOP});
		rdreg(ADDR_COMMAND);
		`CHK({rd[15:0], program_counter}, {16'h000a, 16'h000a})
		rdreg(ADDR_ACC);
		`CHK({rd, resp}, {32'h000000ff, RESP_OKAY})
		rdreg(8'h30);
		`CHK(resp, RESP_SLVERR)
		wr(8'h30, 32'h00000001);
		`CHK(resp, RESP_SLVERR)
		$display("map test done");
		print_verdict();
	end
endmodule : alu_status_multiplier_core_tb
